// ==== hdl/pbt_chan.sv ====
/*
  One pulse channel: emits one pulse per shared period while active and
  counts a finite burst down. Assumes the sequencer aligns start with the
  first period and gives the period phase on the shared timebase.
*/
`timescale 1ns/1ps
module pbt_chan
  import pbt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Sequencer control
  input  wire logic        start,
  input  wire logic        halt,
  input  wire logic        enable,
  input  wire logic        finite,
  input  wire logic [31:0] count,
  // Shared timebase
  input  wire logic        wrap,
  input  wire logic        high_half,
  // Channel output
  output logic             pulse_out,
  output logic             active
);

  logic        active_q;
  logic        active_d;
  logic [31:0] left_q;
  logic [31:0] left_d;
  logic        pulse_q;
  wire  [31:0] load_cnt = (count == 32'h0) ? PBT_RST_BURST : count;
  wire         last     = finite && (left_q == PBT_RST_BURST);

  always_comb begin
    active_d = active_q;
    left_d   = left_q;
    if (halt) begin
      active_d = 1'b0;
    end else if (start) begin
      active_d = enable;
      left_d   = load_cnt;
    end else if (active_q && wrap) begin
      if (last) begin
        active_d = 1'b0;
      end else if (finite) begin
        left_d = left_q - 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      active_q <= 1'b0;
      left_q   <= 32'h0;
      pulse_q  <= 1'b0;
    end else begin
      active_q <= active_d;
      left_q   <= left_d;
      // Continuous mode never decrements, so it runs until halted
      pulse_q  <= active_d && (start ? 1'b1 : high_half);
    end
  end

  assign pulse_out = pulse_q;
  // Next-cycle activity, so the sequencer sees a burst end on its last wrap
  assign active    = active_d;

endmodule

// ==== hdl/pbt_pkg.sv ====
/*
  Package of the pulse burst trigger sequencer: register offsets, field
  positions, reset values, modes, states and the configuration carrier.
  Assumes a 32-bit AHB-Lite bus with single word transfers only.
*/
package pbt_pkg;

  // Register byte offsets
  localparam logic [7:0] PBT_OFF_CTRL   = 8'h00;
  localparam logic [7:0] PBT_OFF_CMD    = 8'h04;
  localparam logic [7:0] PBT_OFF_CHEN   = 8'h08;
  localparam logic [7:0] PBT_OFF_BURST0 = 8'h0c;
  localparam logic [7:0] PBT_OFF_BURST1 = 8'h10;
  localparam logic [7:0] PBT_OFF_PERIOD = 8'h14;
  localparam logic [7:0] PBT_OFF_SEG    = 8'h18;
  localparam logic [7:0] PBT_OFF_STATUS = 8'h1c;

  // Control register fields
  localparam int PBT_CTRL_SRC_EXT  = 0;
  localparam int PBT_CTRL_TOUT_EN  = 1;
  localparam int PBT_CTRL_POL_POS  = 2;
  localparam int PBT_CTRL_SRC_ONLY = 3;
  localparam int PBT_CTRL_SEG_MODE = 4;

  // Command register fields
  localparam int PBT_CMD_START   = 0;
  localparam int PBT_CMD_HALT    = 1;
  localparam int PBT_CMD_MODE_LO = 2;

  // Segment register fields
  localparam int PBT_SEG_CNT_LO = 8;

  // Status register fields
  localparam int PBT_ST_RUN     = 0;
  localparam int PBT_ST_MODE_LO = 1;
  localparam int PBT_ST_ACT_LO  = 3;
  localparam int PBT_ST_TOUT    = 5;
  localparam int PBT_ST_SEG_LO  = 8;

  // Reset values
  localparam logic [4:0]  PBT_RST_CTRL   = 5'h04;
  localparam logic [1:0]  PBT_RST_CHEN   = 2'h0;
  localparam logic [31:0] PBT_RST_BURST  = 32'h00000001;
  localparam logic [31:0] PBT_RST_PERIOD = 32'h00000064;
  localparam logic [10:0] PBT_RST_SEG    = 11'h0ff;

  // Shortest period that still has a high and a low half
  localparam logic [31:0] PBT_MIN_PERIOD = 32'h00000002;

  localparam int PBT_NCH = 2;

  typedef enum logic [1:0] {
    PBT_MODE_CONT  = 2'b00,
    PBT_MODE_BURST = 2'b01,
    PBT_MODE_GATED = 2'b11
  } pbt_mode_e;

  typedef enum logic [1:0] {
    PBT_ST_IDLE = 2'b00,
    PBT_ST_RUNS = 2'b01,
    PBT_ST_TAIL = 2'b11
  } pbt_state_e;

  typedef struct packed {
    logic src_ext;
    logic tout_en;
    logic pol_pos;
    logic src_only;
    logic seg_mode;
  } pbt_ctrl_s;

endpackage

// ==== hdl/pbt_top.sv ====
/*
  Pulse burst trigger sequencer for a two-channel pulse generator, with an
  AHB-Lite register slave, a shared period timebase and the trigger output.
  Assumes one 125 MHz clock, synchronous inputs and word-only transfers.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module pbt_top
  import pbt_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // AHB-Lite slave request
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  // AHB-Lite slave response
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // External trigger input
  input  wire logic               ext_trig_in,
  // Pulse outputs
  output logic      [PBT_NCH-1:0] pulse_out,
  // Trigger output
  output logic                    trigger_out_signal,
  // Sequencer status
  output logic                    running
);

  // Register state
  pbt_ctrl_s   ctrl_q;
  logic [1:0]  chen_q;
  logic [31:0] burst_q [PBT_NCH];
  logic [31:0] period_q;
  logic [10:0] seg_q;
  logic [31:0] hrdata_q;

  // Bus data phase state
  logic        wr_q;
  logic [7:0]  waddr_q;

  // Sequencer state
  pbt_state_e  state_q;
  pbt_state_e  state_d;
  pbt_mode_e   mode_q;
  pbt_mode_e   mode_d;
  logic [31:0] per_cnt_q;
  logic [31:0] per_cnt_d;
  logic [2:0]  seg_idx_q;
  logic [2:0]  seg_idx_d;
  logic        tout_q;
  logic        ext_q;

  // Address phase decode
  wire        addr_ok  = hsel && htrans[1] && hready;
  wire        rd_req   = addr_ok && !hwrite;
  wire        wr_req   = addr_ok && hwrite;
  wire [7:0]  raddr    = haddr[7:0];
  wire        in_range = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);

  // Data phase write strobes
  wire        wr_ctrl  = wr_q && (waddr_q == PBT_OFF_CTRL);
  wire        wr_cmd   = wr_q && (waddr_q == PBT_OFF_CMD);
  wire        wr_chen  = wr_q && (waddr_q == PBT_OFF_CHEN);
  wire        wr_b0    = wr_q && (waddr_q == PBT_OFF_BURST0);
  wire        wr_b1    = wr_q && (waddr_q == PBT_OFF_BURST1);
  wire        wr_per   = wr_q && (waddr_q == PBT_OFF_PERIOD);
  wire        wr_seg   = wr_q && (waddr_q == PBT_OFF_SEG);

  // Commands
  wire        cmd_halt = wr_cmd && hwdata[PBT_CMD_HALT];
  wire        cmd_go   = wr_cmd && hwdata[PBT_CMD_START] && !ctrl_q.src_ext;
  wire [1:0]  cmd_mode = hwdata[PBT_CMD_MODE_LO +: 2];
  // Trigger input only exists in the source-only command set
  wire        ext_edge = ext_trig_in && !ext_q;
  wire        ext_go   = ctrl_q.src_only && ctrl_q.src_ext && ext_edge;
  wire        go       = (cmd_go || ext_go) && !cmd_halt;

  // Shared timebase; channels read one counter so they stay in step
  // Periods below two act as two, so each half lasts a cycle
  wire [31:0] per_eff  = (period_q < PBT_MIN_PERIOD) ? PBT_MIN_PERIOD : period_q;
  wire [31:0] per_half = {1'b0, per_eff[31:1]};
  wire        tb_run   = (state_q != PBT_ST_IDLE);
  wire        wrap     = tb_run && (per_cnt_q == per_eff - 32'h1);
  wire        hi_next  = (per_cnt_d < per_half);

  // Channel status
  logic [PBT_NCH-1:0] ch_act;
  wire        any_act  = |ch_act;
  wire        finite   = (mode_q != PBT_MODE_CONT);

  // Segment flag of the cycle ahead; the index moves on at the wrap
  wire [2:0]  seg_last = seg_q[PBT_SEG_CNT_LO +: 3];
  wire [2:0]  seg_next = seg_idx_d;
  wire        seg_flag = !ctrl_q.seg_mode || seg_q[seg_next];

  // Trigger source activity per state
  wire        trig_live = (state_q == PBT_ST_RUNS) || (state_q == PBT_ST_TAIL);

  // Read mux
  logic [31:0] rd_word;
  wire [31:0] st_word = {16'h0, 5'h0, seg_idx_q, 2'h0,
                         tout_q, ch_act, mode_q, tb_run};

  always_comb begin
    rd_word = 32'h0;
    unique case (raddr)
      PBT_OFF_CTRL:   rd_word = {27'h0, ctrl_q.seg_mode, ctrl_q.src_only, ctrl_q.pol_pos,
                                 ctrl_q.tout_en, ctrl_q.src_ext};
      PBT_OFF_CHEN:   rd_word = {30'h0, chen_q};
      PBT_OFF_BURST0: rd_word = burst_q[0];
      PBT_OFF_BURST1: rd_word = burst_q[1];
      PBT_OFF_PERIOD: rd_word = period_q;
      PBT_OFF_SEG:    rd_word = {21'h0, seg_q};
      PBT_OFF_STATUS: rd_word = st_word;
      default:        rd_word = 32'h0;
    endcase
  end

  // Bus slave registers
  // Zero wait states: read word captured in the address phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q     <= 1'b0;
      waddr_q  <= 8'h0;
      hrdata_q <= 32'h0;
    end else begin
      wr_q     <= wr_req && in_range;
      waddr_q  <= raddr;
      if (rd_req) begin
        hrdata_q <= in_range ? rd_word : 32'h0;
      end
    end
  end

  // Configuration registers
  // Counts apply at the next start; the period applies at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q     <= pbt_ctrl_s'(PBT_RST_CTRL);
      chen_q     <= PBT_RST_CHEN;
      burst_q[0] <= PBT_RST_BURST;
      burst_q[1] <= PBT_RST_BURST;
      period_q   <= PBT_RST_PERIOD;
      seg_q      <= PBT_RST_SEG;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.src_ext  <= hwdata[PBT_CTRL_SRC_EXT];
        ctrl_q.tout_en  <= hwdata[PBT_CTRL_TOUT_EN];
        ctrl_q.pol_pos  <= hwdata[PBT_CTRL_POL_POS];
        ctrl_q.src_only <= hwdata[PBT_CTRL_SRC_ONLY];
        ctrl_q.seg_mode <= hwdata[PBT_CTRL_SEG_MODE];
      end
      if (wr_chen) begin
        chen_q <= hwdata[1:0];
      end
      if (wr_b0) begin
        burst_q[0] <= hwdata;
      end
      if (wr_b1) begin
        burst_q[1] <= hwdata;
      end
      if (wr_per) begin
        period_q <= hwdata;
      end
      if (wr_seg) begin
        seg_q <= hwdata[10:0];
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    per_cnt_d = per_cnt_q;
    seg_idx_d = seg_idx_q;
    // Halt wins over a start in the same write
    if (cmd_halt) begin
      state_d   = PBT_ST_IDLE;
      per_cnt_d = 32'h0;
      seg_idx_d = 3'h0;
    end else if (go) begin
      state_d   = PBT_ST_RUNS;
      per_cnt_d = 32'h0;
      seg_idx_d = 3'h0;
      if (ext_go) begin
        mode_d = PBT_MODE_BURST;
      end else begin
        unique case (cmd_mode)
          2'b01:   mode_d = PBT_MODE_BURST;
          2'b10:   mode_d = PBT_MODE_GATED;
          default: mode_d = PBT_MODE_CONT;
        endcase
      end
    end else begin
      if (tb_run) begin
        per_cnt_d = wrap ? 32'h0 : per_cnt_q + 32'h1;
        if (wrap) begin
          seg_idx_d = (seg_idx_q == seg_last) ? 3'h0 : seg_idx_q + 3'h1;
        end
      end
      unique case (state_q)
        PBT_ST_IDLE: state_d = PBT_ST_IDLE;
        PBT_ST_RUNS: begin
          if (finite && !any_act) begin
            // Gated bursts end the timebase with the last pulse
            state_d = (mode_q == PBT_MODE_GATED) ? PBT_ST_IDLE : PBT_ST_TAIL;
          end
        end
        PBT_ST_TAIL: state_d = PBT_ST_TAIL;
        default:     state_d = PBT_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= PBT_ST_IDLE;
      mode_q    <= PBT_MODE_CONT;
      per_cnt_q <= 32'h0;
      seg_idx_q <= 3'h0;
      ext_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      per_cnt_q <= per_cnt_d;
      seg_idx_q <= seg_idx_d;
      ext_q     <= ext_trig_in;
    end
  end

  // Trigger: same period and phase as the pulses, high half then low half.
  // Gated mode stops with the channels, plain burst keeps the timebase.
  // A start always passes, since the mode held then is the old one
  wire gate_ok    = go || (mode_q != PBT_MODE_GATED) || any_act;
  wire trig_src   = trig_live || go;
  wire trig_keep  = !cmd_halt && gate_ok;
  wire trig_phase = go ? 1'b1 : hi_next;
  wire trig_next  = ctrl_q.tout_en
                    && trig_src && trig_keep
                    && seg_flag
                    && trig_phase;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tout_q <= 1'b0;
    end else begin
      tout_q <= trig_next;
    end
  end

  // Channels; activity is next-cycle, so a gated burst closes on its last wrap
  for (genvar i = 0; i < PBT_NCH; i++) begin : g_ch
    pbt_chan u_chan (
      .mclk      (mclk),
      .rst       (rst),
      .start     (go),
      .halt      (cmd_halt),
      .enable    (chen_q[i]),
      .finite    (go ? (mode_d != PBT_MODE_CONT) : finite),
      .count     (burst_q[i]),
      .wrap      (wrap),
      .high_half (hi_next),
      .pulse_out (pulse_out[i]),
      .active    (ch_act[i])
    );
  end

  // Negative polarity idles high and gives a falling active edge
  assign trigger_out_signal = ctrl_q.pol_pos ? tout_q : !tout_q;
  assign running            = tb_run;
  // Zero wait states, always OKAY
  assign hrdata             = hrdata_q;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;

endmodule

// ==== tb/pbt_scope.sv ====
/*
  Instrument on the trigger output: counts active edges only.
  Assumes the trigger line is level-stable between clock edges.
*/
`timescale 1ns/1ps
module pbt_scope (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Trigger line and the edge it treats as active
  input  wire logic trig_in,
  input  wire logic rising,
  // Active edges seen
  output int        edges
);
  logic last_q;

  // Like a scope set to edge trigger: the other edge is ignored
  always_ff @(posedge mclk) begin
    last_q <= trig_in;
    if (rst)
      edges <= 0;
    else if (trig_in !== last_q && trig_in === rising)
      edges <= edges + 1;
  end
endmodule

// ==== tb/pbt_top_monitor.sv ====
/*
  Checker of the pulse burst trigger sequencer, bound to its top module.
  Assumes word writes only; shadows the control fields from the bus.
*/
`timescale 1ns/1ps
module pbt_top_monitor
  import pbt_pkg::*;
(
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Bus
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  // Outputs
  input wire logic [PBT_NCH-1:0] pulse_out,
  input wire logic               trigger_out_signal,
  input wire logic               running
);
  logic        wv_q;
  logic [7:0]  wa_q;
  logic [4:0]  ctrl_q;
  logic [1:0]  chen_q;
  logic [31:0] per_q;
  logic [3:0]  hi_q;
  wire         wcmd = wv_q && wa_q == PBT_OFF_CMD;
  wire         ext  = ctrl_q[PBT_CTRL_SRC_EXT];
  wire         go   = wcmd && hwdata[PBT_CMD_START] && !hwdata[PBT_CMD_HALT] && !ext && chen_q != 2'h0;
  wire         stop = wcmd && hwdata[PBT_CMD_HALT];
  wire         pol  = ctrl_q[PBT_CTRL_POL_POS];
  wire         ten  = ctrl_q[PBT_CTRL_TOUT_EN];

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Shadows move at the end of the data phase, like the slave
  always_ff @(posedge mclk) begin
    if (rst) begin
      wv_q   <= 1'b0;
      wa_q   <= 8'h00;
      ctrl_q <= PBT_RST_CTRL;
      chen_q <= PBT_RST_CHEN;
      per_q  <= PBT_RST_PERIOD;
      hi_q   <= 4'h0;
    end else begin
      wv_q <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
      wa_q <= haddr[7:0];
      if (wv_q && wa_q == PBT_OFF_CTRL) ctrl_q <= hwdata[4:0];
      if (wv_q && wa_q == PBT_OFF_CHEN) chen_q <= hwdata[1:0];
      if (wv_q && wa_q == PBT_OFF_PERIOD) per_q <= hwdata;
      hi_q <= !trigger_out_signal ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
    end
  end

  AST_START: assert property (go |=> running && pulse_out == chen_q)
    else $error("start did not launch the enabled channels");
  AST_TRIG_FIRST: assert property (go && ten && !ctrl_q[PBT_CTRL_SEG_MODE] |=> trigger_out_signal == pol)
    else $error("first trigger pulse missing or wrong polarity");
  AST_HALT: assert property (stop |=> !running && pulse_out == '0)
    else $error("halt left output active");
  AST_IDLE: assert property (!running |-> pulse_out == '0)
    else $error("pulse while idle");
  AST_CHEN: assert property ((pulse_out & ~chen_q) == '0)
    else $error("pulse on a channel switched off");
  AST_TOUT_OFF: assert property (!ten [*2] |-> trigger_out_signal == !pol)
    else $error("trigger active while disabled");
  AST_IDLE_TRIG: assert property (!running [*2] |-> trigger_out_signal == !pol)
    else $error("trigger active while idle");
  AST_REFUSE: assert property (wcmd && hwdata[PBT_CMD_START] && ext && !running |=> !running)
    else $error("software start taken with external source");
  AST_HALF: assert property (pol && $past(pol) && per_q == 32'h8 |-> hi_q <= 4'h4)
    else $error("trigger high longer than half period");

  COV_START: cover property (go);
  COV_HALT: cover property (stop && running);
  COV_END: cover property ($fell(running));
endmodule

bind pbt_top pbt_top_monitor mon (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .pulse_out(pulse_out),
  .trigger_out_signal(trigger_out_signal), .running(running));

// ==== tb/pbt_top_tb.sv ====
/*
  Testbench of the pulse burst trigger sequencer: AHB-Lite master tasks,
  pulse counters and a scope model. Assumes a zero-wait-state slave.
*/
`timescale 1ns/1ps
module pbt_top_tb
  import pbt_pkg::*;
;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic               hsel = 1'b1;
  logic               hwrite = 1'b0;
  logic               ext_trig_in = 1'b0;
  logic               pol_pos = 1'b1;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        rd_q;
  logic [PBT_NCH-1:0] pl_q = '0;
  wire logic [31:0]   hrdata;
  wire logic          hreadyout, hresp, trigger_out_signal, running;
  wire logic [1:0]    pulse_out;
  int                 rises [PBT_NCH];
  int                 edges, e0, run_len, last_hi, cyc, n_errors, check_count;

  pbt_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_trig_in(ext_trig_in), .pulse_out(pulse_out),
    .trigger_out_signal(trigger_out_signal), .running(running));
  pbt_scope scope (.mclk(mclk), .rst(rst), .trig_in(trigger_out_signal), .rising(pol_pos), .edges(edges));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // Rise counts per channel and the last high run of channel 0
  always @(posedge mclk) begin
    pl_q <= pulse_out;
    for (int c = 0; c < PBT_NCH; c++) begin
      if (pulse_out[c] === 1'b1 && pl_q[c] === 1'b0) rises[c]++;
    end
    if (pulse_out[0] === 1'b1) run_len++;
    else if (pl_q[0] === 1'b1) begin
      last_hi = run_len;
      run_len = 0;
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, rd_q, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Halt first, then source, counts and channels; control never written last
  task automatic setup(input logic [4:0] c, input logic [1:0] en, input logic [31:0] b0);
    wr(PBT_OFF_CMD, 32'h2);
    pol_pos <= c[PBT_CTRL_POL_POS];
    wr(PBT_OFF_CTRL, {27'h0, c});
    wr(PBT_OFF_BURST0, b0);
    wr(PBT_OFF_BURST1, 32'h1);
    wr(PBT_OFF_PERIOD, 32'h8);
    wr(PBT_OFF_CHEN, {30'h0, en});
  endtask

  // Status is read during the run, so n counts from the start edge
  task automatic launch(input logic [31:0] cmd, input logic [1:0] m, input int n);
    rises = '{default: 0};
    e0 = edges;
    wr(PBT_OFF_CMD, cmd);
    bus(1'b0, PBT_OFF_STATUS, 32'h0);
    check("mode", rd_q[2:0], {m, 1'b1});
    wt(n - 2);
  endtask

  task automatic t_reset;
    check("resp", {hreadyout, hresp}, 32'h2);
    rchk("ctrl", PBT_OFF_CTRL, 32'h4);
    rchk("chen", PBT_OFF_CHEN, 32'h0);
    rchk("burst", PBT_OFF_BURST1, 32'h1);
    rchk("period", PBT_OFF_PERIOD, 32'h64);
    rchk("seg", PBT_OFF_SEG, 32'hff);
    rchk("status", PBT_OFF_STATUS, 32'h0);
    wr(8'h20, 32'hffffffff);
    rchk("unmapped", 8'h20, 32'h0);
  endtask

  task automatic t_modes;
    setup(5'h06, 2'h1, 32'h1);
    launch(32'hd, 2'h0, 80);
    check("cont", rises[0], 10);
    check("off_ch", rises[1], 0);
    check("trig", edges - e0, 10);
    check("half", last_hi, 4);
    wr(PBT_OFF_CMD, 32'h2);
    wt(2);
    check("halt", {running, pulse_out}, 0);
    setup(5'h06, 2'h3, 32'h3);
    launch(32'h5, 2'h1, 80);
    check("burst0", rises[0], 3);
    check("burst1", rises[1], 1);
    check("tail", edges - e0, 10);
    check("tail_run", running, 1);
    setup(5'h06, 2'h1, 32'h3);
    launch(32'h9, 2'h3, 80);
    check("gated", rises[0], 3);
    check("gtrig", edges - e0, 3);
    check("gidle", running, 0);
  endtask

  task automatic t_trig;
    setup(5'h00, 2'h1, 32'h1);
    launch(32'h1, 2'h0, 40);
    check("dis", edges - e0, 0);
    check("dis_lvl", trigger_out_signal, 1);
    setup(5'h02, 2'h1, 32'h1);
    launch(32'h1, 2'h0, 40);
    check("neg", edges - e0, 5);
    setup(5'h16, 2'h1, 32'h1);
    wr(PBT_OFF_SEG, 32'h305);
    launch(32'h1, 2'h0, 80);
    check("seg_p", rises[0], 10);
    check("seg_t", edges - e0, 5);
  endtask

  task automatic ext_pulse;
    rises = '{default: 0};
    ext_trig_in <= 1'b1;
    wt(3);
    ext_trig_in <= 1'b0;
    wt(80);
  endtask

  task automatic t_ext;
    setup(5'h07, 2'h1, 32'h2);
    wr(PBT_OFF_CMD, 32'h1);
    wt(2);
    check("refused", running, 0);
    ext_pulse();
    check("no_src", rises[0], 0);
    setup(5'h0f, 2'h1, 32'h2);
    ext_pulse();
    check("ext", rises[0], 2);
    wr(PBT_OFF_CMD, 32'h2);
  endtask

  task final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_trig();
    t_ext();
    final_report();
  end
endmodule
